// >>> core/chip_reset_regs.vh
// chip_reset_regs.vh: constants of the chip reset controller
`ifndef CHIP_RESET_REGS_VH
`define CHIP_RESET_REGS_VH

// input clock period and derived sequence lengths
`define CLK_PERIOD_NS      10
`define SOFT_TAIL_NS       160
`define SOFT_TAIL_CYC      (`SOFT_TAIL_NS / `CLK_PERIOD_NS)
`define CFG_WAIT_CYC       15369
`define HARD_HOLD_CYC      64
`define SOFT_HOLD_CYC      64

// reset cause bit positions
`define CAUSE_W            8
`define CAUSE_POR          0
`define CAUSE_HARD_PIN     1
`define CAUSE_SOFT_PIN     2
`define CAUSE_WDOG         3
`define CAUSE_TAP          4
`define CAUSE_LINK         5
`define CAUSE_SW_HARD      6
`define CAUSE_SW_SOFT      7
`define CAUSE_RST          8'h00

// boundary-scan command codes and which of them drive the soft pin
`define BSCAN_EXTEST       2'h0
`define BSCAN_CLAMP        2'h1
`define BSCAN_HIGHZ        2'h2
`define BSCAN_DRV_MASK     4'h1

// configuration capture widths and reset values
`define CFG_SRC_W          3
`define CFG_FIELD_W        17
`define CFG_SRC_RST        3'h0
`define CFG_FIELD_RST      17'h00000

`endif

// >>> core/chip_reset_controller.v
// chip_reset_controller.v: central reset sequencer for the processor
`timescale 1ns/1ns
`include "chip_reset_regs.vh"

module chip_reset_controller #(
    parameter CFG_CYCLES  = `CFG_WAIT_CYC,
    parameter HARD_CYCLES = `HARD_HOLD_CYC,
    parameter SOFT_CYCLES = `SOFT_HOLD_CYC,
    parameter CNT_W       = 18
) (
    input  wire                     i_clk,
    input  wire                     i_rst_n,
    input  wire                     i_power_on_reset_n,
    input  wire                     i_hard_reset_n,
    output wire                     o_hard_reset_n,
    output reg                      o_hard_reset_n_oe,
    input  wire                     i_soft_reset_n,
    output wire                     o_soft_reset_n,
    output reg                      o_soft_reset_n_oe,
    input  wire [`CFG_SRC_W-1:0]    i_config_source_select,
    input  wire [`CFG_FIELD_W-1:0]  i_config_field,
    input  wire                     i_wdog_zero,
    input  wire                     i_wdog_enable,
    input  wire                     i_tap_host_reset,
    input  wire                     i_bscan_req,
    input  wire [1:0]               i_bscan_cmd,
    input  wire                     i_link_hard_reset,
    input  wire                     i_sw_hard_req,
    input  wire                     i_sw_soft_req,
    output reg  [`CAUSE_W-1:0]      o_reset_cause,
    output reg  [`CFG_SRC_W-1:0]    o_config_source_select,
    output reg  [`CFG_FIELD_W-1:0]  o_config_field,
    output reg                      o_pll_reset,
    output reg                      o_cfg_word_load,
    output reg                      o_sys_cfg_sample,
    output reg                      o_periph_reset,
    output reg                      o_ext_cores_reset,
    output reg                      o_full_reset,
    output reg                      o_partial_reset,
    output reg                      o_busy
);

    localparam ST_IDLE = 3'h0;
    localparam ST_POR  = 3'h1;
    localparam ST_CFG  = 3'h2;
    localparam ST_HARD = 3'h3;
    localparam ST_TAIL = 3'h4;
    localparam ST_SOFT = 3'h5;

    // counts kept as integers, cut to the counter width on purpose
    localparam integer CFG_LAST_I  = CFG_CYCLES - 1;
    localparam integer HARD_LAST_I = HARD_CYCLES - 1;
    localparam integer SOFT_LAST_I = SOFT_CYCLES - 1;
    localparam integer TAIL_LAST_I = `SOFT_TAIL_CYC - 1;
    localparam [CNT_W-1:0] CFG_LAST  = CFG_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] HARD_LAST = HARD_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] SOFT_LAST = SOFT_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] TAIL_LAST = TAIL_LAST_I[CNT_W-1:0];

    // hard-level states keep the hard pin low
    function drives_hard;
        input [2:0] st;
        begin
            drives_hard = (st == ST_POR) || (st == ST_CFG) || (st == ST_HARD);
        end
    endfunction

    // pin synchronisers, third stage only for edge detection
    reg  [1:0]               por_sync_ff;
    reg  [2:0]               hard_sync_ff;
    reg  [2:0]               soft_sync_ff;
    reg  [`CFG_SRC_W-1:0]    src_meta_ff;
    reg  [`CFG_SRC_W-1:0]    src_sync_ff;
    reg  [`CFG_FIELD_W-1:0]  field_meta_ff;
    reg  [`CFG_FIELD_W-1:0]  field_sync_ff;

    reg  [2:0]               state_ff;
    reg  [2:0]               nxt_state;
    reg  [CNT_W-1:0]         cnt_ff;
    reg  [CNT_W-1:0]         nxt_cnt;
    reg  [`CAUSE_W-1:0]      nxt_cause;
    reg                      drv_soft_ff;
    reg                      nxt_drv_soft;
    reg                      nxt_cfg_capture;
    reg                      nxt_sys_sample;

    wire                     req_por;
    wire                     hard_edge;
    wire                     soft_edge;
    wire                     hard_pin_ok;
    wire                     bscan_drv;
    wire [3:0]               bscan_shift;
    wire [`CAUSE_W-1:0]      new_bits;
    wire                     hard_any;
    wire                     soft_any;
    wire                     soft_drv_req;

    // pins only pulled low, the board pull-up makes the high level
    assign o_hard_reset_n = 1'b0;
    assign o_soft_reset_n = 1'b0;

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            por_sync_ff   <= 2'h0;
            hard_sync_ff  <= 3'h7;
            soft_sync_ff  <= 3'h7;
            src_meta_ff   <= `CFG_SRC_RST;
            src_sync_ff   <= `CFG_SRC_RST;
            field_meta_ff <= `CFG_FIELD_RST;
            field_sync_ff <= `CFG_FIELD_RST;
        end
        else
        begin
            por_sync_ff   <= {por_sync_ff[0], i_power_on_reset_n};
            hard_sync_ff  <= {hard_sync_ff[1:0], i_hard_reset_n};
            soft_sync_ff  <= {soft_sync_ff[1:0], i_soft_reset_n};
            src_meta_ff   <= i_config_source_select;
            src_sync_ff   <= src_meta_ff;
            field_meta_ff <= i_config_field;
            field_sync_ff <= field_meta_ff;
        end
    end

    assign req_por   = ~por_sync_ff[1];
    // edges, not levels: the pins echo our own drive for a few cycles
    assign hard_edge = hard_sync_ff[2] & ~hard_sync_ff[1];
    assign soft_edge = soft_sync_ff[2] & ~soft_sync_ff[1];
    // while we pull the hard pin its level tells nothing
    assign hard_pin_ok = (state_ff == ST_IDLE) || (state_ff == ST_SOFT);
    assign bscan_shift = `BSCAN_DRV_MASK >> i_bscan_cmd;
    assign bscan_drv   = bscan_shift[0];

    // every source lands in one cause vector
    assign new_bits[`CAUSE_POR]      = req_por;
    assign new_bits[`CAUSE_HARD_PIN] = hard_edge & hard_pin_ok;
    assign new_bits[`CAUSE_SOFT_PIN] = soft_edge & (state_ff == ST_IDLE);
    assign new_bits[`CAUSE_WDOG]     = i_wdog_zero & i_wdog_enable;
    assign new_bits[`CAUSE_TAP]      = i_tap_host_reset | i_bscan_req;
    assign new_bits[`CAUSE_LINK]     = i_link_hard_reset;
    assign new_bits[`CAUSE_SW_HARD]  = i_sw_hard_req;
    assign new_bits[`CAUSE_SW_SOFT]  = i_sw_soft_req;

    assign hard_any = new_bits[`CAUSE_HARD_PIN] | new_bits[`CAUSE_WDOG] |
                      new_bits[`CAUSE_LINK] | new_bits[`CAUSE_SW_HARD];
    assign soft_any = new_bits[`CAUSE_SOFT_PIN] | new_bits[`CAUSE_TAP] |
                      new_bits[`CAUSE_SW_SOFT];
    assign soft_drv_req = new_bits[`CAUSE_SOFT_PIN] | i_tap_host_reset |
                          new_bits[`CAUSE_SW_SOFT] | (i_bscan_req & bscan_drv);

    always @*
    begin
        nxt_state       = state_ff;
        nxt_cnt         = (cnt_ff != {CNT_W{1'b0}}) ? cnt_ff - 1'b1 : cnt_ff;
        nxt_cause       = o_reset_cause | new_bits;
        nxt_drv_soft    = drv_soft_ff;
        nxt_cfg_capture = 1'b0;
        nxt_sys_sample  = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                // a fresh sequence forgets the previous causes
                nxt_cause = new_bits;
                if (req_por)
                begin
                    nxt_state = ST_POR;
                end
                else if (hard_any)
                begin
                    nxt_state = ST_HARD;
                    nxt_cnt   = HARD_LAST;
                end
                else if (soft_any)
                begin
                    nxt_state    = ST_SOFT;
                    nxt_cnt      = SOFT_LAST;
                    nxt_drv_soft = soft_drv_req;
                end
                else
                begin
                    nxt_cause = o_reset_cause;
                end
            end
            ST_POR:
            begin
                if (!req_por)
                begin
                    nxt_state       = ST_CFG;
                    nxt_cnt         = CFG_LAST;
                    nxt_cfg_capture = 1'b1;
                end
            end
            ST_CFG:
            begin
                if (req_por)
                begin
                    nxt_state = ST_POR;
                end
                else if (cnt_ff == {CNT_W{1'b0}})
                begin
                    nxt_state      = ST_TAIL;
                    nxt_cnt        = TAIL_LAST;
                    nxt_sys_sample = 1'b1;
                end
            end
            ST_HARD:
            begin
                if (req_por)
                begin
                    nxt_state = ST_POR;
                end
                else if (cnt_ff == {CNT_W{1'b0}})
                begin
                    nxt_state      = ST_TAIL;
                    nxt_cnt        = TAIL_LAST;
                    nxt_sys_sample = 1'b1;
                end
            end
            ST_TAIL:
            begin
                if (req_por)
                begin
                    nxt_state = ST_POR;
                end
                else if (hard_any)
                begin
                    nxt_state = ST_HARD;
                    nxt_cnt   = HARD_LAST;
                end
                else if (cnt_ff == {CNT_W{1'b0}})
                begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SOFT:
            begin
                if (req_por)
                begin
                    nxt_state = ST_POR;
                end
                else if (hard_any)
                begin
                    nxt_state = ST_HARD;
                    nxt_cnt   = HARD_LAST;
                end
                else
                begin
                    // a merged request may need the pin the first one left
                    nxt_drv_soft = drv_soft_ff | soft_drv_req;
                    if (cnt_ff == {CNT_W{1'b0}})
                    begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff      <= ST_POR;
            cnt_ff        <= {CNT_W{1'b0}};
            o_reset_cause <= `CAUSE_RST;
            drv_soft_ff   <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            o_reset_cause <= nxt_cause;
            drv_soft_ff   <= nxt_drv_soft;
        end
    end

    // configuration pins are taken only when power-on releases
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_config_source_select <= `CFG_SRC_RST;
            o_config_field         <= `CFG_FIELD_RST;
        end
        else if (nxt_cfg_capture)
        begin
            o_config_source_select <= src_sync_ff;
            o_config_field         <= field_sync_ff;
        end
    end

    // action outputs follow the next state so they line up with it
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_hard_reset_n_oe <= 1'b1;
            o_soft_reset_n_oe <= 1'b1;
            o_pll_reset       <= 1'b1;
            o_cfg_word_load   <= 1'b0;
            o_sys_cfg_sample  <= 1'b0;
            o_periph_reset    <= 1'b1;
            o_ext_cores_reset <= 1'b1;
            o_full_reset      <= 1'b1;
            o_partial_reset   <= 1'b0;
            o_busy            <= 1'b1;
        end
        else
        begin
            o_hard_reset_n_oe <= drives_hard(nxt_state);
            // soft stays low under hard and through the tail
            o_soft_reset_n_oe <= drives_hard(nxt_state) || (nxt_state == ST_TAIL) ||
                                 ((nxt_state == ST_SOFT) && nxt_drv_soft);
            o_pll_reset       <= (nxt_state == ST_POR);
            o_cfg_word_load   <= (nxt_state == ST_CFG);
            o_sys_cfg_sample  <= nxt_sys_sample;
            o_periph_reset    <= (nxt_state != ST_IDLE);
            o_ext_cores_reset <= (nxt_state != ST_IDLE);
            o_full_reset      <= (nxt_state != ST_IDLE) && (nxt_state != ST_SOFT);
            o_partial_reset   <= (nxt_state == ST_SOFT);
            o_busy            <= (nxt_state != ST_IDLE);
        end
    end

endmodule

// >>> test/chip_reset_sva.sv
// assertion checker for the chip reset controller
`timescale 1ns/1ns
`include "chip_reset_regs.vh"
module chip_reset_sva (
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_sw_hard_req,
    input wire logic                 o_hard_reset_n,
    input wire logic                 o_hard_reset_n_oe,
    input wire logic                 o_soft_reset_n,
    input wire logic                 o_soft_reset_n_oe,
    input wire logic [`CAUSE_W-1:0]  o_reset_cause,
    input wire logic                 o_pll_reset,
    input wire logic                 o_cfg_word_load,
    input wire logic                 o_sys_cfg_sample,
    input wire logic                 o_periph_reset,
    input wire logic                 o_ext_cores_reset,
    input wire logic                 o_full_reset,
    input wire logic                 o_partial_reset,
    input wire logic                 o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_soft_only;
        o_soft_reset_n_oe && !o_hard_reset_n_oe;
    endsequence
    // soft pin must outlive the hard pin by the whole tail
    sequence s_tail;
        s_soft_only[*8] ##1 s_soft_only[*8] ##1 !o_soft_reset_n_oe;
    endsequence
    a_soft_with_hard: assert property (o_hard_reset_n_oe |-> o_soft_reset_n_oe)
        else $error("hard pin pulled without soft pin");
    a_pins_never_high: assert property (!o_hard_reset_n && !o_soft_reset_n)
        else $error("reset pin data not low");
    a_pll_por_only: assert property (o_pll_reset |->
        o_hard_reset_n_oe && o_soft_reset_n_oe && o_full_reset)
        else $error("pll reset outside power-on hold");
    a_word_por_only: assert property (o_cfg_word_load |->
        o_hard_reset_n_oe && !o_pll_reset && !o_partial_reset)
        else $error("config word load outside config wait");
    a_sw_hard_start: assert property (!o_busy && i_sw_hard_req |=>
        o_hard_reset_n_oe && o_reset_cause[`CAUSE_SW_HARD])
        else $error("software hard request not started");
    a_tail_length: assert property ($fell(o_hard_reset_n_oe) |-> s_tail)
        else $error("soft release not 16 cycles after hard release");
    a_sample_pulse: assert property ($fell(o_hard_reset_n_oe) |-> o_sys_cfg_sample ##1 !o_sys_cfg_sample)
        else $error("config sample pulse wrong");
    a_busy_actions: assert property (o_busy |-> o_periph_reset && o_ext_cores_reset)
        else $error("sequence without bus and core reset");
    a_partial_soft: assert property (o_partial_reset |-> !o_hard_reset_n_oe && !o_full_reset)
        else $error("partial reset mixed with hard actions");
endmodule
bind chip_reset_controller chip_reset_sva i_chk (.i_clk, .i_rst_n, .i_sw_hard_req, .o_hard_reset_n,
    .o_hard_reset_n_oe, .o_soft_reset_n, .o_soft_reset_n_oe, .o_reset_cause, .o_pll_reset, .o_cfg_word_load,
    .o_sys_cfg_sample, .o_periph_reset, .o_ext_cores_reset, .o_full_reset, .o_partial_reset, .o_busy);

// >>> test/reset_board_model.sv
// board side: power-on supervisor and pulled-up open-drain reset pins
`timescale 1ns/1ns
module reset_board_model (
    input  wire logic i_clk,
    input  wire logic i_por_go,
    input  wire logic i_hard_pull,
    input  wire logic i_soft_pull,
    input  wire logic i_hard_oe,
    input  wire logic i_hard_val,
    input  wire logic i_soft_oe,
    input  wire logic i_soft_val,
    output wire logic o_power_on_reset_n,
    output wire logic o_hard_pin,
    output wire logic o_soft_pin
);
    logic [5:0] por_cnt_ff = 6'h00;
    // supervisor never releases early, so the device sees the full minimum
    always @(posedge i_clk)
        if (i_por_go)
            por_cnt_ff <= 6'h20;
        else if (por_cnt_ff != 6'h00)
            por_cnt_ff <= por_cnt_ff - 6'h01;
    assign o_power_on_reset_n = (por_cnt_ff == 6'h00);
    // pull-ups: a released pin reads high, a driven-high value is not honoured
    assign o_hard_pin = !((i_hard_oe && !i_hard_val) || i_hard_pull);
    assign o_soft_pin = !((i_soft_oe && !i_soft_val) || i_soft_pull);
endmodule

// >>> test/tb_top.sv
// testbench for the chip reset controller
`timescale 1ns/1ns
`include "chip_reset_regs.vh"
module tb_top;
    logic i_clk = 1'b0, i_rst_n = 1'b0, por_go = 1'b0, hard_pull = 1'b0, soft_pull = 1'b0;
    logic wdog_zero = 1'b0, wdog_en = 1'b1, tap = 1'b0, bscan_req = 1'b0, link = 1'b0;
    logic sw_hard = 1'b0, sw_soft = 1'b0;
    logic [1:0]              bscan_cmd = 2'h0;
    logic [`CFG_SRC_W-1:0]   cfg_src = 3'h5;
    logic [`CFG_FIELD_W-1:0] cfg_fld = 17'h1A5A5;
    wire  [`CFG_SRC_W-1:0]   src_q;
    wire  [`CFG_FIELD_W-1:0] fld_q;
    wire  [`CAUSE_W-1:0]     cause;
    wire por_n, hard_pin, soft_pin, hard_n, hard_oe, soft_n, soft_oe, pll, cfg_load, sample;
    wire periph, cores, full, partial, busy;
    int error_cnt = 0, n_tests = 0, cycles = 0;

    always #5 i_clk = ~i_clk;

    chip_reset_controller #(.CFG_CYCLES(20), .HARD_CYCLES(8), .SOFT_CYCLES(8)) i_chip_reset_controller (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_on_reset_n(por_n), .i_hard_reset_n(hard_pin),
        .o_hard_reset_n(hard_n), .o_hard_reset_n_oe(hard_oe), .i_soft_reset_n(soft_pin),
        .o_soft_reset_n(soft_n), .o_soft_reset_n_oe(soft_oe), .i_config_source_select(cfg_src),
        .i_config_field(cfg_fld), .i_wdog_zero(wdog_zero), .i_wdog_enable(wdog_en),
        .i_tap_host_reset(tap), .i_bscan_req(bscan_req), .i_bscan_cmd(bscan_cmd),
        .i_link_hard_reset(link), .i_sw_hard_req(sw_hard), .i_sw_soft_req(sw_soft),
        .o_reset_cause(cause), .o_config_source_select(src_q), .o_config_field(fld_q),
        .o_pll_reset(pll), .o_cfg_word_load(cfg_load), .o_sys_cfg_sample(sample), .o_periph_reset(periph),
        .o_ext_cores_reset(cores), .o_full_reset(full), .o_partial_reset(partial), .o_busy(busy));

    reset_board_model i_reset_board_model (.i_clk(i_clk), .i_por_go(por_go), .i_hard_pull(hard_pull),
        .i_soft_pull(soft_pull), .i_hard_oe(hard_oe), .i_hard_val(hard_n), .i_soft_oe(soft_oe),
        .i_soft_val(soft_n), .o_power_on_reset_n(por_n), .o_hard_pin(hard_pin), .o_soft_pin(soft_pin));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 300)
        begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("idle", busy, 1'b0);
    endtask

    // one-cycle request; returns just after the taking edge
    task automatic fire(input int k);
        @(posedge i_clk);
        case (k)
            0: sw_hard <= 1'b1;
            1: sw_soft <= 1'b1;
            2: link <= 1'b1;
            3: wdog_zero <= 1'b1;
            4: tap <= 1'b1;
            default: bscan_req <= 1'b1;
        endcase
        @(posedge i_clk);
        {sw_hard, sw_soft, link, wdog_zero, tap, bscan_req} <= 6'h00;
        #1;
    endtask

    task automatic t_por();
        @(posedge i_clk);
        por_go <= 1'b1;
        @(posedge i_clk);
        por_go <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        chk("por actions", {pll, hard_oe, soft_oe, cores}, 4'hF);
        // well inside the config wait that follows the power-on hold
        repeat (32) @(posedge i_clk);
        #1;
        chk("cfg load", {pll, cfg_load, hard_oe}, 3'h3);
        wait_idle();
        chk("por cause", cause[`CAUSE_POR], 1'b1);
        chk("cfg captured", {src_q, fld_q}, {3'h5, 17'h1A5A5});
    endtask

    task automatic t_sources();
        logic [7:0] bitv [5] = '{8'h40, 8'h80, 8'h20, 8'h08, 8'h10};
        logic       hardv [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        @(posedge i_clk);
        cfg_src <= 3'h2;
        cfg_fld <= 17'h0F0F0;
        for (int k = 0; k < 5; k++)
        begin
            fire(k);
            chk("cause bit", cause & bitv[k], bitv[k]);
            chk("old cleared", cause[`CAUSE_POR], 1'b0);
            chk("pins", {hard_oe, soft_oe}, {hardv[k], 1'b1});
            chk("reset kind", {full, partial}, {hardv[k], !hardv[k]});
            chk("actions", {periph, cores, pll, cfg_load}, 4'hC);
            wait_idle();
            chk("cfg kept", {src_q, fld_q}, {3'h5, 17'h1A5A5});
        end
    endtask

    task automatic t_tail();
        int n;
        fire(0);
        n = 0;
        while (hard_oe !== 1'b0 && n < 50)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("sample", sample, 1'b1);
        n = 0;
        while (soft_oe !== 1'b0 && n < 50)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("tail", n, 16);
    endtask

    task automatic t_bscan();
        for (int c = 0; c < 3; c++)
        begin
            @(posedge i_clk);
            bscan_cmd <= c[1:0];
            fire(5);
            chk("scan", {cause[`CAUSE_TAP], hard_oe, soft_oe, partial}, {2'b10, c == 0, 1'b1});
            wait_idle();
        end
    endtask

    task automatic t_pins();
        @(posedge i_clk);
        hard_pull <= 1'b1;
        repeat (6) @(posedge i_clk);
        hard_pull <= 1'b0;
        #1;
        chk("hard pin", {cause[`CAUSE_HARD_PIN], hard_oe}, 2'h3);
        wait_idle();
        // soft pin pulled inside a sequence that leaves the pin released, so a real edge arrives
        @(posedge i_clk);
        bscan_cmd <= `BSCAN_CLAMP;
        fire(5);
        @(posedge i_clk);
        soft_pull <= 1'b1;
        repeat (3) @(posedge i_clk);
        soft_pull <= 1'b0;
        wait_idle();
        chk("soft ignored", cause[`CAUSE_SOFT_PIN], 1'b0);
        @(posedge i_clk);
        soft_pull <= 1'b1;
        repeat (6) @(posedge i_clk);
        soft_pull <= 1'b0;
        #1;
        chk("soft pin", {cause[`CAUSE_SOFT_PIN], soft_oe, hard_oe}, 3'h6);
        wait_idle();
        fire(1);
        fire(0);
        chk("upgrade", {cause[`CAUSE_SW_SOFT], cause[`CAUSE_SW_HARD], hard_oe}, 3'h7);
        wait_idle();
        @(posedge i_clk);
        wdog_en <= 1'b0;
        fire(3);
        chk("wdog off", busy, 1'b0);
    endtask

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            error_cnt++;
            conclude();
        end
    end

    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        wait_idle();
        t_por();
        t_sources();
        t_tail();
        t_bscan();
        t_pins();
        conclude();
    end
endmodule
